/* File: verilog/amcfg_top.sv */
// access-window protection and memory-map decode for the core's fetch and
// load/store paths, with an AXI4-Lite register slave.
// assumes address requests synchronous to aclk; results appear one cycle later.
// Function
// - window base is 64-byte aligned
// - window mask low six bits ones
// - mask ones contiguous from the bottom
// - base and mask never share a bit
// - eight instruction windows with enable, base, mask
// - eight independent data windows
// - blocks aligned to own size in region
// - odd sizes aligned to next power two
// - blocks never overlap nor cross regions
// - start is region plus aligned offset
// - instruction local memory presence, region, offset, size
// - data local memory region, offset, size incl 48
// - fetch cache presence, size, protection select
// - interrupt control block region, offset, size
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
module amcfg_top import amcfg_pkg::*; #(
  parameter logic [AMCFG_WINDOWS-1:0] INSTR_WINDOW_ENABLE = 8'h00,
  parameter logic [AMCFG_WINDOWS-1:0][31:0] INSTR_WINDOW_BASE = '0,
  parameter logic [AMCFG_WINDOWS-1:0][31:0] INSTR_WINDOW_MASK = {AMCFG_WINDOWS{32'hFFFF_FFFF}},
  parameter logic [AMCFG_WINDOWS-1:0] DATA_WINDOW_ENABLE = 8'h00,
  parameter logic [AMCFG_WINDOWS-1:0][31:0] DATA_WINDOW_BASE = '0,
  parameter logic [AMCFG_WINDOWS-1:0][31:0] DATA_WINDOW_MASK = {AMCFG_WINDOWS{32'hFFFF_FFFF}},
  parameter logic INSTR_LOCAL_MEM_PRESENT = 1'b1,
  parameter logic [3:0] INSTR_LOCAL_MEM_REGION = 4'hE,
  parameter logic [31:0] INSTR_LOCAL_MEM_OFFSET = 32'h0000_0000,
  parameter int INSTR_LOCAL_MEM_SIZE = 64,
  parameter logic [3:0] DATA_LOCAL_MEM_REGION = 4'hF,
  parameter logic [31:0] DATA_LOCAL_MEM_OFFSET = 32'h0000_0000,
  parameter int DATA_LOCAL_MEM_SIZE = 64,
  parameter logic FETCH_CACHE_PRESENT = 1'b1,
  parameter int FETCH_CACHE_SIZE = 16,
  parameter logic FETCH_CACHE_PROTECT_SEL = 1'b0,
  parameter logic [3:0] IRQ_CTRL_REGS_REGION = 4'hF,
  parameter logic [31:0] IRQ_CTRL_REGS_OFFSET = 32'h00C0_0000,
  parameter int IRQ_CTRL_REGS_SIZE = 32
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic fetch_req_valid, // fetch address present
  input wire logic [31:0] fetch_req_addr, // fetch address
  output logic fetch_resp_valid, // fetch verdict valid
  output logic fetch_allowed, // fetch permitted
  output logic fetch_in_local_mem, // fetch hits instruction local memory
  input wire logic lsu_req_valid, // load/store address present
  input wire logic [31:0] lsu_req_addr, // load/store address
  output logic lsu_resp_valid, // load/store verdict valid
  output logic data_allowed, // load/store permitted
  output logic data_in_local_mem, // hits data local memory
  output logic data_in_irq_ctrl, // hits interrupt control registers
  input wire logic [7:0] s_axil_awaddr, // write address
  input wire logic s_axil_awvalid, // write address valid
  output logic s_axil_awready, // write address ready
  input wire logic [31:0] s_axil_wdata, // write data
  input wire logic [3:0] s_axil_wstrb, // write strobes
  input wire logic s_axil_wvalid, // write data valid
  output logic s_axil_wready, // write data ready
  output logic [1:0] s_axil_bresp, // write response
  output logic s_axil_bvalid, // write response valid
  input wire logic s_axil_bready, // write response ready
  input wire logic [7:0] s_axil_araddr, // read address
  input wire logic s_axil_arvalid, // read address valid
  output logic s_axil_arready, // read address ready
  output logic [31:0] s_axil_rdata, // read data
  output logic [1:0] s_axil_rresp, // read response
  output logic s_axil_rvalid, // read data valid
  input wire logic s_axil_rready // read data ready
);

  localparam logic [31:0] IMEM_START = blk_start(INSTR_LOCAL_MEM_REGION, INSTR_LOCAL_MEM_OFFSET);
  localparam logic [31:0] DMEM_START = blk_start(DATA_LOCAL_MEM_REGION, DATA_LOCAL_MEM_OFFSET);
  localparam logic [31:0] IRQ_START = blk_start(IRQ_CTRL_REGS_REGION, IRQ_CTRL_REGS_OFFSET);

  function automatic logic windows_ok();
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < AMCFG_WINDOWS; i++) begin
      ok &= mask_ok(INSTR_WINDOW_MASK[i]) && mask_ok(DATA_WINDOW_MASK[i]);
      ok &= base_ok(INSTR_WINDOW_BASE[i], INSTR_WINDOW_MASK[i]);
      ok &= base_ok(DATA_WINDOW_BASE[i], DATA_WINDOW_MASK[i]);
    end
    return ok;
  endfunction

  function automatic logic sizes_ok();
    logic ok;
    ok = 1'b1;
    case (INSTR_LOCAL_MEM_SIZE)
      4, 8, 16, 32, 64, 128, 256, 512: ;
      default: ok = 1'b0;
    endcase
    case (DATA_LOCAL_MEM_SIZE)
      4, 8, 16, 32, 48, 64, 128, 256, 512: ;
      default: ok = 1'b0;
    endcase
    case (FETCH_CACHE_SIZE)
      16, 32, 64, 128, 256: ;
      default: ok = 1'b0;
    endcase
    case (IRQ_CTRL_REGS_SIZE)
      32, 64, 128, 256: ;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic placement_ok();
    logic ok;
    ok = place_ok(DATA_LOCAL_MEM_OFFSET, DATA_LOCAL_MEM_SIZE);
    ok &= place_ok(IRQ_CTRL_REGS_OFFSET, IRQ_CTRL_REGS_SIZE);
    ok &= !overlap(DMEM_START, DATA_LOCAL_MEM_SIZE, IRQ_START, IRQ_CTRL_REGS_SIZE);
    if (INSTR_LOCAL_MEM_PRESENT) begin
      ok &= place_ok(INSTR_LOCAL_MEM_OFFSET, INSTR_LOCAL_MEM_SIZE);
      ok &= !overlap(IMEM_START, INSTR_LOCAL_MEM_SIZE, DMEM_START, DATA_LOCAL_MEM_SIZE);
      ok &= !overlap(IMEM_START, INSTR_LOCAL_MEM_SIZE, IRQ_START, IRQ_CTRL_REGS_SIZE);
    end
    return ok;
  endfunction

  localparam logic WIN_OK = windows_ok();
  localparam logic PLACE_OK = sizes_ok() && placement_ok();

  // a build with illegal parameters must not elaborate silently
  if (!WIN_OK) begin : g_bad_windows
    $error("access window base or mask parameter is illegal");
  end
  if (!PLACE_OK) begin : g_bad_placement
    $error("memory placement or size parameter is illegal");
  end

  // window decode; with no window enabled the path is left unrestricted
  logic fetch_win_ok;
  logic data_win_ok;
  always_comb begin
    fetch_win_ok = ~|INSTR_WINDOW_ENABLE;
    data_win_ok = ~|DATA_WINDOW_ENABLE;
    for (int i = 0; i < AMCFG_WINDOWS; i++) begin
      if (window_match(INSTR_WINDOW_ENABLE[i], INSTR_WINDOW_BASE[i], INSTR_WINDOW_MASK[i],
                       fetch_req_addr)) fetch_win_ok = 1'b1;
      if (window_match(DATA_WINDOW_ENABLE[i], DATA_WINDOW_BASE[i], DATA_WINDOW_MASK[i],
                       lsu_req_addr)) data_win_ok = 1'b1;
    end
  end

  logic [31:0] ctrl;
  logic check_en;
  assign check_en = ctrl[AMCFG_CTRL_CHECK_EN];

  logic fetch_hit_imem;
  logic lsu_hit_dmem;
  logic lsu_hit_irq;
  assign fetch_hit_imem = INSTR_LOCAL_MEM_PRESENT &&
                          in_block(fetch_req_addr, IMEM_START, INSTR_LOCAL_MEM_SIZE);
  assign lsu_hit_dmem = in_block(lsu_req_addr, DMEM_START, DATA_LOCAL_MEM_SIZE);
  assign lsu_hit_irq = in_block(lsu_req_addr, IRQ_START, IRQ_CTRL_REGS_SIZE);

  logic fetch_deny;
  logic data_deny;
  assign fetch_deny = fetch_req_valid && check_en && !fetch_win_ok;
  assign data_deny = lsu_req_valid && check_en && !data_win_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_resp_valid <= 1'b0;
      fetch_allowed <= 1'b0;
      fetch_in_local_mem <= 1'b0;
    end else begin
      fetch_resp_valid <= fetch_req_valid;
      fetch_allowed <= fetch_req_valid && !fetch_deny;
      fetch_in_local_mem <= fetch_req_valid && fetch_hit_imem;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lsu_resp_valid <= 1'b0;
      data_allowed <= 1'b0;
      data_in_local_mem <= 1'b0;
      data_in_irq_ctrl <= 1'b0;
    end else begin
      lsu_resp_valid <= lsu_req_valid;
      data_allowed <= lsu_req_valid && !data_deny;
      data_in_local_mem <= lsu_req_valid && lsu_hit_dmem;
      data_in_irq_ctrl <= lsu_req_valid && lsu_hit_irq;
    end
  end

  // AXI4-Lite write side: address and data latched in either order
  amcfg_wstate_t wstate;
  logic aw_held;
  logic w_held;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic do_write;
  assign s_axil_awready = (wstate == AMCFG_W_IDLE) && !aw_held;
  assign s_axil_wready = (wstate == AMCFG_W_IDLE) && !w_held;
  assign do_write = (wstate == AMCFG_W_IDLE) && aw_held && w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate <= AMCFG_W_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= 8'h00;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= AMCFG_RESP_OKAY;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_held <= 1'b1;
        waddr <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_held <= 1'b1;
        wdata <= s_axil_wdata;
        wstrb <= s_axil_wstrb;
      end
      unique case (wstate)
        AMCFG_W_IDLE: begin
          if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axil_bvalid <= 1'b1;
            s_axil_bresp <= reg_mapped(waddr) ? AMCFG_RESP_OKAY : AMCFG_RESP_SLVERR;
            wstate <= AMCFG_W_RESP;
          end
        end
        AMCFG_W_RESP: begin
          if (s_axil_bready) begin
            s_axil_bvalid <= 1'b0;
            wstate <= AMCFG_W_IDLE;
          end
        end
      endcase
    end
  end

  function automatic logic reg_mapped(input logic [7:0] a);
    return (a[7:2] <= AMCFG_REG_FAULT_COUNT[7:2]);
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  logic wr_ctrl;
  logic wr_status;
  logic wr_count;
  assign wr_ctrl = do_write && (waddr[7:2] == AMCFG_REG_CTRL[7:2]);
  assign wr_status = do_write && (waddr[7:2] == AMCFG_REG_STATUS[7:2]) && wstrb[0];
  assign wr_count = do_write && (waddr[7:2] == AMCFG_REG_FAULT_COUNT[7:2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= AMCFG_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= apply_strb(ctrl, wdata, wstrb) & AMCFG_CTRL_RESET;
    end
  end

  // fault capture; a new fault in the clearing cycle keeps its flag
  logic fetch_fault;
  logic data_fault;
  logic [31:0] fetch_fault_addr;
  logic [31:0] data_fault_addr;
  logic [31:0] fault_count;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_fault <= 1'b0;
      data_fault <= 1'b0;
      fetch_fault_addr <= 32'h0000_0000;
      data_fault_addr <= 32'h0000_0000;
    end else begin
      if (fetch_deny) begin
        fetch_fault <= 1'b1;
        fetch_fault_addr <= fetch_req_addr;
      end else if (wr_status && wdata[AMCFG_ST_FETCH_FAULT]) begin
        fetch_fault <= 1'b0;
      end
      if (data_deny) begin
        data_fault <= 1'b1;
        data_fault_addr <= lsu_req_addr;
      end else if (wr_status && wdata[AMCFG_ST_DATA_FAULT]) begin
        data_fault <= 1'b0;
      end
    end
  end

  // counter saturates instead of wrapping so a long run never reads as clean
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_count <= 32'h0000_0000;
    end else if (fetch_deny || data_deny) begin
      if (fault_count != 32'hFFFF_FFFF) fault_count <= fault_count + 32'h1;
    end else if (wr_count) begin
      fault_count <= 32'h0000_0000;
    end
  end

  logic [31:0] status;
  always_comb begin
    status = 32'h0000_0000;
    status[AMCFG_ST_WIN_OK] = WIN_OK;
    status[AMCFG_ST_PLACE_OK] = PLACE_OK;
    status[AMCFG_ST_IMEM_PRESENT] = INSTR_LOCAL_MEM_PRESENT;
    status[AMCFG_ST_CACHE_PRESENT] = FETCH_CACHE_PRESENT;
    status[AMCFG_ST_CACHE_PROT] = FETCH_CACHE_PRESENT && FETCH_CACHE_PROTECT_SEL;
    status[AMCFG_ST_FETCH_FAULT] = fetch_fault;
    status[AMCFG_ST_DATA_FAULT] = data_fault;
  end

  // AXI4-Lite read side
  amcfg_rstate_t rstate;
  assign s_axil_arready = (rstate == AMCFG_R_IDLE);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstate <= AMCFG_R_IDLE;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h0000_0000;
      s_axil_rresp <= AMCFG_RESP_OKAY;
    end else begin
      unique case (rstate)
        AMCFG_R_IDLE: begin
          if (s_axil_arvalid) begin
            s_axil_rvalid <= 1'b1;
            s_axil_rresp <= reg_mapped(s_axil_araddr) ? AMCFG_RESP_OKAY : AMCFG_RESP_SLVERR;
            case (s_axil_araddr[7:2])
              AMCFG_REG_CTRL[7:2]: s_axil_rdata <= ctrl;
              AMCFG_REG_STATUS[7:2]: s_axil_rdata <= status;
              AMCFG_REG_FETCH_FAULT[7:2]: s_axil_rdata <= fetch_fault_addr;
              AMCFG_REG_DATA_FAULT[7:2]: s_axil_rdata <= data_fault_addr;
              AMCFG_REG_FAULT_COUNT[7:2]: s_axil_rdata <= fault_count;
              default: s_axil_rdata <= 32'h0000_0000;
            endcase
            rstate <= AMCFG_R_DATA;
          end
        end
        AMCFG_R_DATA: begin
          if (s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
            rstate <= AMCFG_R_IDLE;
          end
        end
      endcase
    end
  end

  a_fetch_fault_log: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_req_valid && check_en && !fetch_win_ok |=>
      fetch_fault && !fetch_allowed && fetch_fault_addr == $past(fetch_req_addr))
    else $error("denied fetch not logged");
  a_check_off_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_req_valid && !check_en |=> fetch_allowed)
    else $error("fetch refused with checking off");
  a_data_win_verdict: assert property (@(posedge aclk) disable iff (!aresetn)
    lsu_req_valid ##1 lsu_resp_valid |-> data_allowed == (!$past(check_en) ||
      $past(data_win_ok)))
    else $error("data verdict disagrees with windows");
  a_data_mem_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    lsu_req_valid |=> data_in_local_mem == in_block($past(lsu_req_addr), DMEM_START,
      DATA_LOCAL_MEM_SIZE))
    else $error("data local memory decode wrong");
  a_irq_block_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    lsu_req_valid |=> data_in_irq_ctrl == in_block($past(lsu_req_addr), IRQ_START,
      IRQ_CTRL_REGS_SIZE))
    else $error("interrupt control block decode wrong");
  a_imem_absent: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_req_valid |=> fetch_in_local_mem == (INSTR_LOCAL_MEM_PRESENT &&
      in_block($past(fetch_req_addr), IMEM_START, INSTR_LOCAL_MEM_SIZE)))
    else $error("instruction local memory decode wrong");
  a_no_block_overlap: assert property (@(posedge aclk) disable iff (!aresetn)
    !(data_in_local_mem && data_in_irq_ctrl))
    else $error("two blocks claim one address");
  a_verdict_timing: assert property (@(posedge aclk) disable iff (!aresetn)
    !fetch_req_valid |=> !fetch_resp_valid && !fetch_allowed && !fetch_in_local_mem)
    else $error("fetch verdict without request");
  a_fault_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    data_fault && !wr_status |=> data_fault)
    else $error("data fault flag dropped");
  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response dropped early");

  c_fetch_denied: cover property (@(posedge aclk) disable iff (!aresetn) fetch_deny);
  c_irq_access: cover property (@(posedge aclk) disable iff (!aresetn) data_in_irq_ctrl);
  c_ctrl_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_ctrl);
  c_fault_clear: cover property (@(posedge aclk) disable iff (!aresetn)
    data_fault ##1 !data_fault);

endmodule // amcfg_top

/* File: shared/amcfg_pkg.sv */
// package for the access-window and memory-map block: register map, field
// positions, bus states and the parameter check and decode functions.
// assumes a 32-bit address space cut into sixteen regions of 2^28 bytes.
package amcfg_pkg;
  localparam int AMCFG_WINDOWS = 8;
  localparam int AMCFG_ALIGN_BITS = 6;
  localparam logic [5:0] AMCFG_LOW_ONES = 6'h3F;
  localparam int AMCFG_KB_SHIFT = 10;
  localparam logic [32:0] AMCFG_REGION_SPAN = 33'h0_1000_0000;
  localparam int AMCFG_OFFSET_BITS = 28;

  // register byte offsets
  localparam logic [7:0] AMCFG_REG_CTRL = 8'h00;
  localparam logic [7:0] AMCFG_REG_STATUS = 8'h04;
  localparam logic [7:0] AMCFG_REG_FETCH_FAULT = 8'h08;
  localparam logic [7:0] AMCFG_REG_DATA_FAULT = 8'h0C;
  localparam logic [7:0] AMCFG_REG_FAULT_COUNT = 8'h10;

  localparam int AMCFG_CTRL_CHECK_EN = 0;
  localparam logic [31:0] AMCFG_CTRL_RESET = 32'h0000_0001;
  localparam int AMCFG_ST_WIN_OK = 0;
  localparam int AMCFG_ST_PLACE_OK = 1;
  localparam int AMCFG_ST_IMEM_PRESENT = 2;
  localparam int AMCFG_ST_CACHE_PRESENT = 3;
  localparam int AMCFG_ST_CACHE_PROT = 4;
  localparam int AMCFG_ST_FETCH_FAULT = 5;
  localparam int AMCFG_ST_DATA_FAULT = 6;

  localparam logic [1:0] AMCFG_RESP_OKAY = 2'h0;
  localparam logic [1:0] AMCFG_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {AMCFG_W_IDLE = 2'h1, AMCFG_W_RESP = 2'h2} amcfg_wstate_t;
  typedef enum logic [1:0] {AMCFG_R_IDLE = 2'h1, AMCFG_R_DATA = 2'h2} amcfg_rstate_t;

  // mask: low bits all ones, ones packed to the right
  function automatic logic mask_ok(input logic [31:0] m);
    return (m[AMCFG_ALIGN_BITS-1:0] == AMCFG_LOW_ONES) && ((m & (m + 32'h1)) == 32'h0);
  endfunction

  // base: 64-byte aligned and no bit shared with the mask
  function automatic logic base_ok(input logic [31:0] b, input logic [31:0] m);
    return (b[AMCFG_ALIGN_BITS-1:0] == 6'h0) && ((b & m) == 32'h0);
  endfunction

  function automatic logic window_match(input logic en, input logic [31:0] b,
                                        input logic [31:0] m, input logic [31:0] a);
    return en && ((a & ~m) == b);
  endfunction

  function automatic logic [32:0] kb_bytes(input int kb);
    return 33'(kb) << AMCFG_KB_SHIFT;
  endfunction

  // next power of two at or above v
  function automatic logic [32:0] pow2_ceil(input logic [32:0] v);
    logic [32:0] p;
    p = 33'h1;
    for (int i = 0; i < 33; i++) begin
      if (p < v) p = p << 1;
    end
    return p;
  endfunction

  // offset aligned to the size rounded up, block stays within its region
  function automatic logic place_ok(input logic [31:0] off, input int kb);
    logic [32:0] al;
    al = pow2_ceil(kb_bytes(kb));
    return ((33'(off) & (al - 33'h1)) == 33'h0) && (33'(off) + kb_bytes(kb) <= AMCFG_REGION_SPAN);
  endfunction

  function automatic logic [31:0] blk_start(input logic [3:0] region, input logic [31:0] off);
    return {region, off[AMCFG_OFFSET_BITS-1:0]};
  endfunction

  function automatic logic in_block(input logic [31:0] a, input logic [31:0] s, input int kb);
    return (a >= s) && (33'(a - s) < kb_bytes(kb));
  endfunction

  function automatic logic overlap(input logic [31:0] s1, input int kb1,
                                   input logic [31:0] s2, input int kb2);
    return (33'(s1) < 33'(s2) + kb_bytes(kb2)) && (33'(s2) < 33'(s1) + kb_bytes(kb1));
  endfunction
endpackage

/* File: bench/amcfg_core_model.sv */
// model of the core's fetch and load/store address paths facing the block.
// assumes one probe at a time; the verdict is read one cycle after the request.
`timescale 1ns/100ps
module amcfg_core_model (
  input wire logic aclk, // clock
  output logic fetch_req_valid, // fetch address present
  output logic [31:0] fetch_req_addr, // fetch address
  input wire logic fetch_resp_valid, // fetch verdict valid
  input wire logic fetch_allowed, // fetch permitted
  input wire logic fetch_in_local_mem, // fetch hits local memory
  output logic lsu_req_valid, // load/store address present
  output logic [31:0] lsu_req_addr, // load/store address
  input wire logic lsu_resp_valid, // load/store verdict valid
  input wire logic data_allowed, // load/store permitted
  input wire logic data_in_local_mem, // hits data local memory
  input wire logic data_in_irq_ctrl // hits interrupt control block
);
  initial begin
    fetch_req_valid = 1'b0;
    fetch_req_addr = 32'h0000_0000;
    lsu_req_valid = 1'b0;
    lsu_req_addr = 32'h0000_0000;
  end

  // after the request the address shows its inverse, never a stale copy
  task automatic probe(input logic side, input logic [31:0] a, output logic rv,
                       output logic ok, output logic mem, output logic irq);
    @(posedge aclk);
    if (side) begin
      lsu_req_valid <= 1'b1;
      lsu_req_addr <= a;
    end else begin
      fetch_req_valid <= 1'b1;
      fetch_req_addr <= a;
    end
    @(posedge aclk);
    lsu_req_valid <= 1'b0;
    fetch_req_valid <= 1'b0;
    lsu_req_addr <= ~a;
    fetch_req_addr <= ~a;
    @(posedge aclk);
    rv = side ? lsu_resp_valid : fetch_resp_valid;
    ok = side ? data_allowed : fetch_allowed;
    mem = side ? data_in_local_mem : fetch_in_local_mem;
    irq = side ? data_in_irq_ctrl : 1'b0;
  endtask
endmodule // amcfg_core_model

/* File: bench/amcfg_top_bench.sv */
// self-checking bench: window verdicts, map decode and the register slave.
// assumes the default placement: imem E/0 64KB, dmem F/0 64KB, irq F/C00000 32KB.
`timescale 1ns/100ps
module amcfg_top_bench;
  import amcfg_pkg::*;
  typedef struct {logic side; logic [31:0] a; logic ok; logic mem; logic irq;} amcfg_probe_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic fv, fa, fok, fmem, lv, lrv, lok, lmem, lirq;
  logic [31:0] faddr, laddr, rdata, wdata, rd;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rv, ok, mem, irq;
  logic [1:0] bresp, rresp, resp;
  int fail_count = 0, tests_run = 0, cycles = 0;
  amcfg_probe_t tbl [11];
  always #50 aclk = ~aclk;
  amcfg_top #(.INSTR_WINDOW_ENABLE(8'h01), .INSTR_WINDOW_BASE({224'h0, 32'h0000_1000}),
    .INSTR_WINDOW_MASK({{7{32'hFFFF_FFFF}}, 32'h0000_0FFF}), .DATA_WINDOW_ENABLE(8'h01),
    .DATA_WINDOW_BASE({192'h0, 32'h1000_0000, 32'hF000_0000}),
    .DATA_WINDOW_MASK({{6{32'hFFFF_FFFF}}, 32'h0000_0FFF, 32'h0FFF_FFFF})) DUT (
    .aclk(aclk), .aresetn(aresetn), .fetch_req_valid(fv), .fetch_req_addr(faddr),
    .fetch_resp_valid(fa), .fetch_allowed(fok), .fetch_in_local_mem(fmem),
    .lsu_req_valid(lv), .lsu_req_addr(laddr), .lsu_resp_valid(lrv), .data_allowed(lok),
    .data_in_local_mem(lmem), .data_in_irq_ctrl(lirq), .s_axil_awaddr(awaddr),
    .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
    .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
    .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
    .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready));
  amcfg_core_model core (.aclk(aclk), .fetch_req_valid(fv), .fetch_req_addr(faddr),
    .fetch_resp_valid(fa), .fetch_allowed(fok), .fetch_in_local_mem(fmem),
    .lsu_req_valid(lv), .lsu_req_addr(laddr), .lsu_resp_valid(lrv), .data_allowed(lok),
    .data_in_local_mem(lmem), .data_in_irq_ctrl(lirq));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
  endtask
  task summarize;
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // a hung handshake ends here as a counted mismatch
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    wdata = 32'h0000_0000;
    tbl = '{'{1'b0, 32'h0000_1000, 1'b1, 1'b0, 1'b0}, '{1'b0, 32'h0000_1FFF, 1'b1, 1'b0, 1'b0},
            '{1'b0, 32'h0000_2000, 1'b0, 1'b0, 1'b0}, '{1'b0, 32'h0000_0FC0, 1'b0, 1'b0, 1'b0},
            '{1'b0, 32'hE000_0100, 1'b0, 1'b1, 1'b0}, '{1'b1, 32'hF000_0040, 1'b1, 1'b1, 1'b0},
            '{1'b1, 32'hF000_FFFF, 1'b1, 1'b1, 1'b0}, '{1'b1, 32'hF001_0000, 1'b1, 1'b0, 1'b0},
            '{1'b1, 32'hF0C0_7FFC, 1'b1, 1'b0, 1'b1}, '{1'b1, 32'hF0C0_8000, 1'b1, 1'b0, 1'b0},
            '{1'b1, 32'h1000_0000, 1'b0, 1'b0, 1'b0}};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(AMCFG_REG_CTRL); chk("ctrl reset", rd, 32'h0000_0001);
    axr(AMCFG_REG_STATUS); chk("status reset", rd, 32'h0000_000F);
    axr(8'h20); chk("unmapped read resp", {30'h0, resp}, {30'h0, AMCFG_RESP_SLVERR});
    foreach (tbl[i]) begin
      core.probe(tbl[i].side, tbl[i].a, rv, ok, mem, irq);
      chk("verdict valid", {31'h0, rv}, 32'h1);
      chk("allowed", {31'h0, ok}, {31'h0, tbl[i].ok});
      chk("in local memory", {31'h0, mem}, {31'h0, tbl[i].mem});
      chk("in irq block", {31'h0, irq}, {31'h0, tbl[i].irq});
    end
    axr(AMCFG_REG_FETCH_FAULT); chk("fetch fault addr", rd, 32'hE000_0100);
    axr(AMCFG_REG_DATA_FAULT); chk("data fault addr", rd, 32'h1000_0000);
    axr(AMCFG_REG_FAULT_COUNT); chk("fault count", rd, 32'h0000_0004);
    axr(AMCFG_REG_STATUS); chk("status faults", rd, 32'h0000_006F);
    axw(AMCFG_REG_STATUS, 32'h0000_0020, 4'h1);
    axr(AMCFG_REG_STATUS); chk("status clear", rd, 32'h0000_004F);
    axw(AMCFG_REG_FAULT_COUNT, 32'h0000_0000, 4'hF);
    axr(AMCFG_REG_FAULT_COUNT); chk("count clear", rd, 32'h0000_0000);
    axw(8'h14, 32'h0000_0000, 4'hF); chk("unmapped write resp", {30'h0, resp}, 32'h2);
    axw(AMCFG_REG_CTRL, 32'h0000_0000, 4'hF);
    core.probe(1'b0, 32'h0000_2000, rv, ok, mem, irq);
    chk("unchecked fetch", {31'h0, ok}, 32'h1);
    axw(AMCFG_REG_CTRL, 32'hFFFF_FFFF, 4'hF);
    axr(AMCFG_REG_CTRL); chk("ctrl ro bits", rd, 32'h0000_0001);
    core.probe(1'b1, 32'h1000_0000, rv, ok, mem, irq);
    chk("disabled window", {31'h0, ok}, 32'h0);
    summarize();
  end
endmodule // amcfg_top_bench
